// file: logic/ppom_pkg.sv
/*
 * types of the port pin override mux.
 * assumes ppom_regs.svh for the numeric constants.
 */
`default_nettype none

package ppom_pkg;

    // override bundle that one peripheral presents for one pin
    typedef struct packed {
        logic pullup_override_en;
        logic pullup_override_val;
        logic dir_override_en;
        logic dir_override_val;
        logic value_override_en;
        logic value_override_val;
        logic toggle_override_en;
        logic input_en_override_en;
        logic input_en_override_val;
    } ppom_ovr_type;

    // pad controls of the whole port
    typedef struct packed {
        logic [7:0] drive_en;
        logic [7:0] drive_val;
        logic [7:0] pullup_en;
    } ppom_pad_type;

    // resolved controls of one pin
    typedef struct packed {
        logic drive_en;
        logic drive_val;
        logic pullup_en;
    } ppom_pin_type;

endpackage : ppom_pkg

`default_nettype wire

// file: logic/ppom_port_pin_override_mux.sv
/*
 * port pin override mux for one eight-bit port: latch, direction,
 * pin synchroniser, per-pin peripheral overrides and the routing of
 * the unsynchronised input to the fixed alternate functions.
 * assumes every input except pad_in_i is synchronous to clk_i and that peripherals
 * resynchronise alt_digital_in themselves.
 */
//
// Contract
// RULE1: pull-up override enable makes pull-up follow its override value only.
// RULE2: without override, pull-up on only for direction/latch/disable 010.
// RULE3: without direction override, driver enable follows direction bit.
// RULE4: with direction override, driver enable follows override value.
// RULE5: driver enabled and value override set: pin drives override value.
// RULE6: driver enabled, no value override: pin drives output latch.
// RULE7: toggle override enable inverts the stored output latch bit.
// RULE8: without input override, input enable follows normal or sleep state.
// RULE9: with input override, input enable follows its override value.
// RULE10: alt digital input taken after trigger, before pin synchroniser.
// RULE11: peripherals synchronise alt digital input unless used as clock.
// RULE12: peripherals generate pin override enables and values themselves; the mux makes the pin 1 value and pin 2 input overrides itself.
// RULE13: clock, sleep, global pull-up disable shared; overrides per pin.
// RULE14: software waits one idle cycle before reading back written pins; the two-stage synchroniser here needs two idle cycles.
// RULE15: port bit n feeds pin change source n, n from 0 to 7.
// RULE16: bit 2 is external interrupt 1 and serial clock in both modes.
// RULE17: bit 1 carries three-wire data out of the serial unit.
// RULE18: bit 0 is serial data in, three-wire and two-wire modes.
// RULE19: bit 4 supplies timer 0 capture input besides pin change.
// RULE20: writing one to a pin sample bit toggles its output latch bit.
// RULE21: sleep clamps inputs unless override or enabled ext interrupt.
// RULE22: disabled driver ignores pin value; reset clears override enables.

`default_nettype none

`include "ppom_regs.svh"

module ppom_port_pin_override_mux
    import ppom_pkg::*;
#(
    parameter int WIDTH = `PPOM_PORT_WIDTH
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // software access to latch, direction and pin locations
    input  wire logic               latch_wr_i,
    input  wire logic [WIDTH-1:0]   latch_wdata_i,
    input  wire logic               dir_wr_i,
    input  wire logic [WIDTH-1:0]   dir_wdata_i,
    input  wire logic               sample_wr_i,
    input  wire logic [WIDTH-1:0]   sample_wdata_i,
    // shared controls
    input  wire logic               sleep_i,
    input  wire logic               pullup_global_disable_i,
    input  wire logic               ext_irq1_enable_i,
    // serial unit mode and data
    input  wire logic               three_wire_mode_i,
    input  wire logic               two_wire_mode_i,
    input  wire logic               three_wire_data_out_i,
    // per-pin peripheral overrides
    input  wire ppom_ovr_type [WIDTH-1:0] ovr_i,
    // pad side
    input  wire logic [WIDTH-1:0]   pad_in_i,
    output var  ppom_pad_type       pad_o,
    // register read-back
    output logic [WIDTH-1:0]        output_latch_o,
    output logic [WIDTH-1:0]        direction_o,
    output logic [WIDTH-1:0]        pin_sample_o,
    // unsynchronised input to peripherals
    output logic [WIDTH-1:0]        alt_digital_in_o,
    output logic [WIDTH-1:0]        pin_change_source_o,
    output logic                    ext_irq1_input_o,
    output logic                    serial_clock_pin_o,
    output logic                    two_wire_clock_o,
    output logic                    three_wire_data_in_o,
    output logic                    two_wire_data_o,
    output logic                    capture_input0_o
);

    // resolve one pin from its overrides and register bits
    function automatic ppom_pin_type resolve_pin(
        input ppom_ovr_type ovr,
        input logic         dir,
        input logic         latch,
        input logic         pullup_global_disable
    );
        ppom_pin_type res;
        if (ovr.pullup_override_en) begin
            res.pullup_en = ovr.pullup_override_val;        // see RULE1
        end else begin
            res.pullup_en =
                ({dir, latch, pullup_global_disable} == `PPOM_PULLUP_PATTERN); // see RULE2
        end
        res.drive_en = ovr.dir_override_en ?
            ovr.dir_override_val : dir;                  // see RULE3 RULE4
        res.drive_val = ovr.value_override_en ?
            ovr.value_override_val : latch;              // see RULE5 RULE6
        // a disabled driver leaves the level meaningless
        if (!res.drive_en) begin
            res.drive_val = 1'b0;                        // see RULE22
        end
        return res;
    endfunction : resolve_pin

    // register state
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sample_q;
    logic [WIDTH-1:0] alt_q;
    logic [WIDTH-1:0] alt_d;
    ppom_pad_type     pad_q;
    ppom_pad_type     pad_d;
    ppom_ovr_type [WIDTH-1:0] ovr_eff;
    logic [WIDTH-1:0] in_en;

    // merged overrides; reset forces every enable low
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            ovr_eff[i] = rst_i ? '0 : ovr_i[i];          // see RULE22
        end
        // serial data out takes pin 1 value in three-wire mode
        if (!rst_i && three_wire_mode_i) begin
            ovr_eff[`PPOM_PIN_SER_OUT].value_override_en  = 1'b1;
            ovr_eff[`PPOM_PIN_SER_OUT].value_override_val =
                three_wire_data_out_i;                   // see RULE17
        end
        // an enabled external interrupt keeps its input alive in sleep
        if (!rst_i && ext_irq1_enable_i) begin
            ovr_eff[`PPOM_PIN_SER_CLK].input_en_override_en  = 1'b1;
            ovr_eff[`PPOM_PIN_SER_CLK].input_en_override_val = 1'b1;
        end                                              // see RULE21
    end

    // latch and direction next values
    always_comb begin
        latch_d = latch_wr_i ? latch_wdata_i : latch_q;
        // pin location write of ones flips the latch
        if (sample_wr_i) begin
            latch_d = latch_d ^ sample_wdata_i;          // see RULE20
        end
        for (int i = 0; i < WIDTH; i++) begin
            if (ovr_eff[i].toggle_override_en) begin
                latch_d[i] = ~latch_d[i];                // see RULE7
            end
        end
        dir_d = dir_wr_i ? dir_wdata_i : dir_q;
    end

    // latch and direction registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= `PPOM_LATCH_RST;
            dir_q   <= `PPOM_DIR_RST;
        end else begin
            latch_q <= latch_d;
            dir_q   <= dir_d;
        end
    end

    // pad controls; shared pud, private overrides
    always_comb begin
        pad_d = '0;
        for (int i = 0; i < WIDTH; i++) begin
            ppom_pin_type r;
            r = resolve_pin(ovr_eff[i], dir_d[i], latch_d[i],
                            pullup_global_disable_i);    // see RULE13
            pad_d.drive_en[i]  = r.drive_en;
            pad_d.drive_val[i] = r.drive_val;
            pad_d.pullup_en[i] = r.pullup_en;
        end
    end

    // pad register; tri-state and no pull-up during reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_q <= '0;
        end else begin
            pad_q <= pad_d;
        end
    end

    // input enable and clamp ahead of the trigger
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (ovr_eff[i].input_en_override_en) begin
                in_en[i] = ovr_eff[i].input_en_override_val; // see RULE9
            end else begin
                in_en[i] = ~sleep_i;                     // see RULE8 RULE21
            end
        end
        alt_d = pad_in_i & in_en;
    end

    // single stage to peripherals; they add their own sync
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_q <= '0;
        end else begin
            alt_q <= alt_d;                              // see RULE10
        end
    end

    // two-stage synchroniser toward the pin sample location
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_q   <= '0;
            sample_q <= '0;
        end else begin
            sync_q   <= alt_d;
            sample_q <= sync_q;
        end
    end

    // outputs straight from flops
    assign pad_o          = pad_q;
    assign output_latch_o = latch_q;
    assign direction_o    = dir_q;
    assign pin_sample_o   = sample_q;
    assign alt_digital_in_o = alt_q;

    // fixed alternate function routing
    assign pin_change_source_o  = alt_q;                 // see RULE15
    assign ext_irq1_input_o     = alt_q[`PPOM_PIN_SER_CLK]; // see RULE16
    assign serial_clock_pin_o   = alt_q[`PPOM_PIN_SER_CLK]; // see RULE16
    assign two_wire_clock_o     = alt_q[`PPOM_PIN_SER_CLK]; // see RULE16
    assign three_wire_data_in_o = alt_q[`PPOM_PIN_SER_DATA]; // see RULE18
    assign two_wire_data_o      = alt_q[`PPOM_PIN_SER_DATA]; // see RULE18
    assign capture_input0_o     = alt_q[`PPOM_PIN_CAPTURE]; // see RULE19

    // two-wire mode flag is decoded inside the serial unit itself
    logic unused_mode;
    assign unused_mode = two_wire_mode_i;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pullup_override: assert property ( // see RULE1
        !$past(rst_i) && $past(ovr_i[5].pullup_override_en)
        |-> pad_o.pullup_en[5] == $past(ovr_i[5].pullup_override_val))
        else $error("pull-up ignores its override");

    a_pullup_default: assert property ( // see RULE2
        !$past(rst_i) && !$past(ovr_i[5].pullup_override_en)
        |-> pad_o.pullup_en[5] ==
            (!direction_o[5] && output_latch_o[5]
             && !$past(pullup_global_disable_i)))
        else $error("default pull-up pattern wrong");

    a_drive_default: assert property ( // see RULE3
        !$past(rst_i) && !$past(ovr_i[6].dir_override_en)
        |-> pad_o.drive_en[6] == direction_o[6])
        else $error("driver does not follow direction");

    a_drive_override: assert property ( // see RULE4
        !$past(rst_i) && $past(ovr_i[6].dir_override_en)
        |-> pad_o.drive_en[6] == $past(ovr_i[6].dir_override_val))
        else $error("driver ignores direction override");

    a_value_source: assert property ( // see RULE5
        !$past(rst_i) && pad_o.drive_en[6]
        && $past(ovr_i[6].value_override_en)
        |-> pad_o.drive_val[6] == $past(ovr_i[6].value_override_val))
        else $error("pin level ignores value override");

    a_latch_value: assert property ( // see RULE6
        !$past(rst_i) && pad_o.drive_en[0]
        && !$past(ovr_i[0].value_override_en)
        |-> pad_o.drive_val[0] == output_latch_o[0])
        else $error("pin level not from latch");

    a_toggle_latch: assert property ( // see RULE7
        !latch_wr_i && !sample_wr_i && ovr_i[2].toggle_override_en
        |=> output_latch_o[2] != $past(output_latch_o[2]))
        else $error("toggle override did not flip latch");

    a_sample_toggle: assert property ( // see RULE20
        sample_wr_i && !latch_wr_i && !ovr_i[1].toggle_override_en
        && !three_wire_mode_i
        |=> output_latch_o[1] ==
            ($past(output_latch_o[1]) ^ $past(sample_wdata_i[1])))
        else $error("sample write did not toggle latch");

    a_sleep_clamp: assert property ( // see RULE8
        sleep_i && !ovr_i[6].input_en_override_en
        |=> !alt_digital_in_o[6])
        else $error("sleeping input not clamped");

    a_sync_delay: assert property ( // see RULE10
        !$past(rst_i)
        |-> pin_sample_o == $past(alt_digital_in_o))
        else $error("sample not one stage behind alt input");

    a_capture_route: assert property ( // see RULE19
        capture_input0_o == alt_digital_in_o[4]
        && ext_irq1_input_o == alt_digital_in_o[2])
        else $error("alternate routing broken");

    a_off_driver: assert property ( // see RULE22
        !pad_o.drive_en[2] |-> !pad_o.drive_val[2])
        else $error("level shown with driver off");

    c_pullup_on: cover property (pad_o.pullup_en[0] ##1 pad_o.drive_en[0]);
    c_toggle:    cover property (ovr_i[1].toggle_override_en [*2]);
    c_sleep:     cover property (sleep_i ##1 alt_digital_in_o[2]);
    c_serial:    cover property (three_wire_mode_i ##1 pad_o.drive_en[1]);

endmodule : ppom_port_pin_override_mux

`default_nettype wire

// file: logic/ppom_regs.svh
/*
 * constants of the port pin override mux: widths, pin positions,
 * reset values and the default pull-up pattern.
 * assumes nothing beyond being included once per compilation unit.
 */
`ifndef PPOM_REGS_SVH
`define PPOM_REGS_SVH

// port geometry
`define PPOM_PORT_WIDTH     8
// pin positions of the fixed alternate functions
`define PPOM_PIN_SER_DATA   0
`define PPOM_PIN_SER_OUT    1
`define PPOM_PIN_SER_CLK    2
`define PPOM_PIN_CAPTURE    4
// {direction, latch, global disable} that turns a pull-up on
`define PPOM_PULLUP_PATTERN 3'h2
// reset values
`define PPOM_LATCH_RST      8'h00
`define PPOM_DIR_RST        8'h00

`endif

// file: tb/ppom_pad_model.sv
/* pad and board model for the eight port pins.
   assumes pad controls from the mux and an optional board drive. */
`default_nettype none
module ppom_pad_model
    import ppom_pkg::*;
(
    // clock
    input  wire logic         clk_i,
    // pad controls and board drive
    input  wire ppom_pad_type pad_i,
    input  wire logic [7:0]   ext_en_i,
    input  wire logic [7:0]   ext_val_i,
    // resolved pin levels
    output logic [7:0]        level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_q = 8'h00;
    // floating pins flip each cycle so a stale level never reads as valid
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_i.drive_en[i])
                level_o[i] = pad_i.drive_val[i];
            else if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else if (pad_i.pullup_en[i])
                level_o[i] = 1'b1;
            else
                level_o[i] = ~last_q[i];
        end
    end
    // remember the level for the floating case
    always @(posedge clk_i) begin
        last_q <= level_o;
    end
endmodule : ppom_pad_model
`default_nettype wire

// file: tb/ppom_tb.sv
/* self-checking bench of the port pin override mux.
   assumes the pad model on the pins; the bench acts as peripherals. */
`default_nettype none
module tb;
    import ppom_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         lwr = 1'b0, dwr = 1'b0, swr = 1'b0;
    logic [7:0]   ld = 8'h00, dd = 8'h00, sd = 8'h00;
    logic         sleep = 1'b0, pullup_global_disable = 1'b0, irq1_en = 1'b0;
    logic         tw3 = 1'b0, tw2 = 1'b0, tdo = 1'b0;
    ppom_ovr_type [7:0] ovr = '0;
    logic [7:0]   ext_en = 8'h00, ext_val = 8'h00, pad_in;
    ppom_pad_type pad;
    logic [7:0]   lat, dir, smp, alt, pcs;
    logic         irq1, sclk, twclk, tdi, twd, cap;
    int           bad_count = 0, tests_run = 0, cycles = 0;

    ppom_port_pin_override_mux ppom_port_pin_override_mux_inst (
        .clk_i(clk_i), .rst_i(rst_i),
        .latch_wr_i(lwr), .latch_wdata_i(ld),
        .dir_wr_i(dwr), .dir_wdata_i(dd),
        .sample_wr_i(swr), .sample_wdata_i(sd),
        .sleep_i(sleep), .pullup_global_disable_i(pullup_global_disable),
        .ext_irq1_enable_i(irq1_en), .three_wire_mode_i(tw3),
        .two_wire_mode_i(tw2), .three_wire_data_out_i(tdo),
        .ovr_i(ovr), .pad_in_i(pad_in), .pad_o(pad),
        .output_latch_o(lat), .direction_o(dir), .pin_sample_o(smp),
        .alt_digital_in_o(alt), .pin_change_source_o(pcs),
        .ext_irq1_input_o(irq1), .serial_clock_pin_o(sclk),
        .two_wire_clock_o(twclk), .three_wire_data_in_o(tdi),
        .two_wire_data_o(twd), .capture_input0_o(cap));

    ppom_pad_model ppom_pad_model_inst (
        .clk_i(clk_i), .pad_i(pad), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .level_o(pad_in));

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // let the launching edge land, then look
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask : step

    // write latch and direction in one cycle
    task automatic regs(input logic [7:0] l, input logic [7:0] d);
        @(posedge clk_i);
        lwr <= 1'b1;
        ld <= l;
        dwr <= 1'b1;
        dd <= d;
        @(posedge clk_i);
        lwr <= 1'b0;
        dwr <= 1'b0;
        #1;
    endtask : regs

    // hang guard: the whole run needs well under 200 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(pad, 24'h0, "reset pads");
        chk({lat, dir}, 24'h0, "reset regs");
        regs(8'h36, 8'h0f);
        chk(pad, {8'h0f, 8'h06, 8'h30}, "gpio pads");
        chk(dir, 24'h0f, "gpio direction");
        @(posedge clk_i);
        pullup_global_disable <= 1'b1;
        step();
        chk(pad.pullup_en, 24'h0, "global disable");
        @(posedge clk_i);
        swr <= 1'b1;
        sd <= 8'h81;
        @(posedge clk_i);
        swr <= 1'b0;
        #1;
        chk(lat, 24'hb7, "sample toggle");
        $display("test gpio done");
        // peripherals present their own overrides
        @(posedge clk_i);
        pullup_global_disable <= 1'b0;
        ovr[5].pullup_override_en <= 1'b1;
        ovr[0].pullup_override_en <= 1'b1;
        ovr[0].pullup_override_val <= 1'b1;
        ovr[6].dir_override_en <= 1'b1;
        ovr[6].dir_override_val <= 1'b1;
        ovr[6].value_override_en <= 1'b1;
        ovr[6].value_override_val <= 1'b1;
        ovr[1].dir_override_en <= 1'b1;
        ovr[3].value_override_en <= 1'b1;
        ovr[3].value_override_val <= 1'b1;
        ovr[7].value_override_en <= 1'b1;
        ovr[7].value_override_val <= 1'b1;
        step();
        chk(pad, {8'h4d, 8'h4d, 8'h91}, "overrides");
        @(posedge clk_i);
        ovr[2].toggle_override_en <= 1'b1;
        @(posedge clk_i);
        ovr <= '0;
        #1;
        chk(lat, 24'hb3, "toggle override");
        $display("test override done");
        @(posedge clk_i);
        dwr <= 1'b1;
        dd <= 8'h00;
        ext_en <= 8'hff;
        @(posedge clk_i);
        dwr <= 1'b0;
        ext_val <= 8'h15;
        step();
        chk(alt, 24'h15, "alt input");
        chk(pcs, 24'h15, "pin change");
        chk({irq1, sclk, twclk, tdi, twd, cap}, 24'h3f, "routing");
        step();
        chk(smp, 24'h15, "pin sample");
        @(posedge clk_i);
        sleep <= 1'b1;
        ext_val <= 8'hff;
        step();
        chk(alt, 24'h00, "sleep clamp");
        @(posedge clk_i);
        irq1_en <= 1'b1;
        step();
        chk(alt, 24'h04, "irq keeps input");
        @(posedge clk_i);
        ovr[7].input_en_override_en <= 1'b1;
        ovr[7].input_en_override_val <= 1'b1;
        step();
        chk(alt, 24'h84, "input override on");
        @(posedge clk_i);
        sleep <= 1'b0;
        ovr[7].input_en_override_val <= 1'b0;
        step();
        chk(alt, 24'h7f, "input override off");
        $display("test input done");
        @(posedge clk_i);
        ovr <= '0;
        tw3 <= 1'b1;
        tdo <= 1'b1;
        lwr <= 1'b1;
        ld <= 8'h00;
        dwr <= 1'b1;
        dd <= 8'h02;
        @(posedge clk_i);
        lwr <= 1'b0;
        dwr <= 1'b0;
        #1;
        chk(pad[23:8], 24'h0202, "serial out high");
        @(posedge clk_i);
        tdo <= 1'b0;
        step();
        chk(pad[23:8], 24'h0200, "serial out low");
        // driven level needs two idle cycles before it reads back
        step();
        step();
        chk(smp, 24'hfd, "read back after idle");
        $display("test serial done");
        conclude();
    end
endmodule : tb
`default_nettype wire
